/* array_counter_pkg.sv */
// constants for the array counter timebase block
// assumes the cpu special function register port and the system clock domain
package array_counter_pkg;

  // ****************************************************************
  // special function register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_COUNTER_MODE  = 8'hd9;  // mode register
  localparam logic [7:0] ADDR_COUNTER_CTRL  = 8'hd8;  // overflow flag lives here
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'hf9;  // counter low byte
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hfa;  // counter high byte
  localparam logic [7:0] ADDR_CAPTURE0_LOW  = 8'hfb;  // capture module 0 low byte
  localparam logic [7:0] ADDR_CAPTURE1_LOW  = 8'he9;  // capture module 1 low byte
  localparam logic [7:0] ADDR_CAPTURE2_LOW  = 8'heb;  // capture module 2 low byte
  localparam logic [7:0] ADDR_CAPTURE3_LOW  = 8'hed;  // capture module 3 low byte
  localparam logic [7:0] ADDR_CAPTURE4_LOW  = 8'hfd;  // capture module 4 low byte

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int         MODE_IDLE_BIT     = 7;       // idle_suspend
  localparam int         MODE_WD_EN_BIT    = 6;       // watchdog_enable
  localparam int         MODE_WD_LOCK_BIT  = 5;       // watchdog_lock
  localparam int         MODE_TB_MSB       = 3;       // timebase_select top
  localparam int         MODE_TB_LSB       = 1;       // timebase_select bottom
  localparam int         MODE_IRQ_EN_BIT   = 0;       // overflow_irq_enable
  localparam int         CTRL_FLAG_BIT     = 7;       // counter_overflow_flag
  localparam logic [7:0] MODE_RESET        = 8'h40;   // watchdog enabled
  localparam logic [7:0] MODE_WRITE_MASK   = 8'hef;   // bit 4 reads zero
  localparam logic [7:0] BYTE_RESET        = 8'h00;   // data registers
  localparam int         NUM_CAPTURE       = 5;       // capture modules

  // ****************************************************************
  // timebase codes and prescaler counts
  // ****************************************************************
  localparam logic [2:0] TB_DIV12   = 3'h0;           // system clock / 12
  localparam logic [2:0] TB_DIV4    = 3'h1;           // system clock / 4
  localparam logic [2:0] TB_TIMER0  = 3'h2;           // timer 0 overflow
  localparam logic [2:0] TB_EXT_EDGE = 3'h3;          // falling external edges
  localparam logic [2:0] TB_SYSCLK  = 3'h4;           // every cycle
  localparam logic [2:0] TB_OSC_DIV8 = 3'h5;          // external oscillator / 8
  localparam logic [3:0] PRESCALE_LAST = 4'hb;        // twelve states, 0..11
  localparam logic [1:0] DIV4_PHASE    = 2'h3;        // every fourth state
  localparam logic [15:0] COUNT_MAX    = 16'hffff;    // wrap point

endpackage

/* array_counter_timebase.sv */
// array counter timebase: 16-bit counter, snapshot read, timebase select,
// overflow flag, idle suspend, watchdog enable and lock, capture low bytes
// assumes a cpu on ref_clk_in driving one-cycle sfr read and write strobes
`timescale 1ns/1ps
module array_counter_timebase
  import array_counter_pkg::*;
(
  input  wire logic       ref_clk_in,            // system clock, 50 MHz
  input  wire logic       rstn_in,               // async reset, active low
  input  wire logic [7:0] sfr_addr_in,           // register address
  input  wire logic       sfr_wr_in,             // write strobe
  input  wire logic       sfr_rd_in,             // read strobe
  input  wire logic [7:0] sfr_wdata_in,          // write data
  output logic      [7:0] sfr_rdata_out,         // read data, registered
  input  wire logic       cpu_idle_in,           // cpu in idle mode
  input  wire logic       timer0_overflow_in,    // one-cycle pulse
  input  wire logic       external_count_input_in, // pin, asynchronous
  input  wire logic       ext_osc_div8_in,       // divided oscillator, async
  input  wire logic       global_irq_enable_in,  // cpu global enable
  input  wire logic       block_irq_enable_in,   // block enable in extended reg
  output logic            irq_out,               // overflow request
  output logic            watchdog_enable_out    // module 4 is watchdog
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] count;                            // live counter
  logic [15:0] next_count;
  logic [7:0]  snapshot;                         // latched high byte
  logic [7:0]  next_snapshot;
  logic [7:0]  mode;                             // counter_mode
  logic [7:0]  next_mode;
  logic        overflow_flag;                    // counter_overflow_flag
  logic        next_overflow_flag;
  logic [7:0]  capture_low [NUM_CAPTURE];        // capture_low_byte array
  logic [7:0]  next_capture_low [NUM_CAPTURE];
  logic [7:0]  next_rdata;
  logic [3:0]  prescale;                         // divide-by-12 state
  logic [3:0]  next_prescale;
  logic [2:0]  ext_count_sync;                   // two sync stages plus history
  logic [2:0]  osc_sync;                         // two sync stages plus history

  // decoded strobes
  logic        wr_mode, wr_ctrl, wr_low, wr_high, rd_low;
  logic        src_tick, count_tick, overflow;
  logic [2:0]  timebase_select;
  logic        idle_suspend, overflow_irq_enable, watchdog_lock;

  assign wr_mode  = sfr_wr_in && (sfr_addr_in == ADDR_COUNTER_MODE);
  assign wr_ctrl  = sfr_wr_in && (sfr_addr_in == ADDR_COUNTER_CTRL);
  assign wr_low   = sfr_wr_in && (sfr_addr_in == ADDR_COUNT_LOW);
  assign wr_high  = sfr_wr_in && (sfr_addr_in == ADDR_COUNT_HIGH);
  assign rd_low   = sfr_rd_in && (sfr_addr_in == ADDR_COUNT_LOW);

  assign timebase_select     = mode[MODE_TB_MSB:MODE_TB_LSB];
  assign idle_suspend        = mode[MODE_IDLE_BIT];
  assign overflow_irq_enable = mode[MODE_IRQ_EN_BIT];
  assign watchdog_lock       = mode[MODE_WD_LOCK_BIT];

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // stage 0 feeds only stage 1; edges are taken between stages 1 and 2
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_count_sync <= 3'h7;
      osc_sync       <= 3'h0;
    end else begin
      ext_count_sync <= {ext_count_sync[1:0], external_count_input_in};
      osc_sync <= {osc_sync[1:0], ext_osc_div8_in};
    end
  end

  // ****************************************************************
  // timebase selection
  // ****************************************************************
  // prescaler runs always so a source change sees a steady phase
  always_comb begin
    next_prescale = (prescale == PRESCALE_LAST) ? 4'h0 : prescale + 4'h1;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prescale <= 4'h0;
    end else begin
      prescale <= next_prescale;
    end
  end

  // one-cycle tick from the selected source
  always_comb begin
    unique case (timebase_select)
      TB_DIV12:    src_tick = (prescale == PRESCALE_LAST);
      TB_DIV4:     src_tick = (prescale[1:0] == DIV4_PHASE);
      TB_TIMER0:   src_tick = timer0_overflow_in;
      TB_EXT_EDGE: src_tick = ext_count_sync[2] && !ext_count_sync[1];
      TB_SYSCLK:   src_tick = 1'b1;
      TB_OSC_DIV8: src_tick = osc_sync[1] && !osc_sync[2];
      default:     src_tick = 1'b0;
    endcase
  end

  // idle suspension gates every source
  assign count_tick = src_tick && !(idle_suspend && cpu_idle_in);
  assign overflow   = count_tick && (count == COUNT_MAX);

  // ****************************************************************
  // counter, snapshot and overflow flag
  // ****************************************************************
  // reads touch only the snapshot, never the count
  always_comb begin
    next_count = count_tick ? count + 16'h0001 : count;
    if (wr_low) begin
      next_count[7:0] = sfr_wdata_in;
    end
    if (wr_high) begin
      next_count[15:8] = sfr_wdata_in;
    end
    next_snapshot = rd_low ? count[15:8] : snapshot;
    // hardware set beats a software clear in the same cycle
    if (overflow) begin
      next_overflow_flag = 1'b1;
    end else if (wr_ctrl) begin
      next_overflow_flag = sfr_wdata_in[CTRL_FLAG_BIT];
    end else begin
      next_overflow_flag = overflow_flag;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count    <= 16'h0000;
      snapshot <= BYTE_RESET;
      overflow_flag <= 1'b0;
    end else begin
      count    <= next_count;
      snapshot <= next_snapshot;
      overflow_flag <= next_overflow_flag;
    end
  end

  // ****************************************************************
  // mode register with watchdog protection
  // ****************************************************************
  // while the watchdog runs only an unlocked disable gets through
  always_comb begin
    next_mode = mode;
    if (wr_mode) begin
      if (!mode[MODE_WD_EN_BIT]) begin
        next_mode = sfr_wdata_in & MODE_WRITE_MASK;
      end else if (!watchdog_lock) begin
        next_mode[MODE_WD_EN_BIT] = sfr_wdata_in[MODE_WD_EN_BIT];
      end
    end
    if (next_mode[MODE_WD_LOCK_BIT]) begin
      next_mode[MODE_WD_EN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode <= MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  assign watchdog_enable_out = mode[MODE_WD_EN_BIT];

  // ****************************************************************
  // capture module low bytes
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < NUM_CAPTURE; i++) begin
      next_capture_low[i] = capture_low[i];
    end
    if (sfr_wr_in) begin
      unique case (sfr_addr_in)
        ADDR_CAPTURE0_LOW: next_capture_low[0] = sfr_wdata_in;
        ADDR_CAPTURE1_LOW: next_capture_low[1] = sfr_wdata_in;
        ADDR_CAPTURE2_LOW: next_capture_low[2] = sfr_wdata_in;
        ADDR_CAPTURE3_LOW: next_capture_low[3] = sfr_wdata_in;
        ADDR_CAPTURE4_LOW: next_capture_low[4] = sfr_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_CAPTURE; i++) begin
        capture_low[i] <= BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CAPTURE; i++) begin
        capture_low[i] <= next_capture_low[i];
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // data answers one cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_rdata = sfr_rdata_out;
    if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        ADDR_COUNTER_MODE: next_rdata = mode;
        ADDR_COUNTER_CTRL: next_rdata = {overflow_flag, 7'h00};
        ADDR_COUNT_LOW:    next_rdata = count[7:0];
        ADDR_COUNT_HIGH:   next_rdata = snapshot;
        ADDR_CAPTURE0_LOW: next_rdata = capture_low[0];
        ADDR_CAPTURE1_LOW: next_rdata = capture_low[1];
        ADDR_CAPTURE2_LOW: next_rdata = capture_low[2];
        ADDR_CAPTURE3_LOW: next_rdata = capture_low[3];
        ADDR_CAPTURE4_LOW: next_rdata = capture_low[4];
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sfr_rdata_out <= 8'h00;
    end else begin
      sfr_rdata_out <= next_rdata;
    end
  end

  // request needs flag, local mask and both cpu enables
  assign irq_out = overflow_flag && overflow_irq_enable
                   && global_irq_enable_in && block_irq_enable_in;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_overflow_sets_flag: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (count_tick && count == 16'hffff && !wr_low && !wr_high)
      |=> (overflow_flag && count == 16'h0000))
    else $error("overflow did not set flag and wrap");

  a_irq_mask_zero: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !mode[0] |-> !irq_out)
    else $error("interrupt raised while masked");

  a_flag_sticks: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (overflow_flag && !wr_ctrl) |=> overflow_flag)
    else $error("flag cleared without software");

  a_irq_needs_enables: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (overflow_flag && mode[0] && global_irq_enable_in && block_irq_enable_in) == irq_out)
    else $error("interrupt request gating wrong");

  a_idle_freezes: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (mode[7] && cpu_idle_in && !wr_low && !wr_high) |=> $stable(count))
    else $error("counter moved in idle suspend");

  a_step_by_one: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (mode[3:1] == 3'h4 && !(mode[7] && cpu_idle_in) && !wr_low && !wr_high)
      |=> count == $past(count) + 16'h0001)
    else $error("counter did not step by one");

  a_reserved_holds: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (mode[3:2] == 2'b11 && !wr_low && !wr_high) |=> $stable(count))
    else $error("counter moved on reserved timebase");

  a_lock_keeps_enable: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    mode[5] |=> (mode[5] && watchdog_enable_out))
    else $error("locked watchdog was disabled");

  a_mode_write_blocked: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (mode[6] && wr_mode) |=> ($stable(mode[5:0]) && $stable(mode[7])))
    else $error("mode changed while watchdog enabled");

  a_snapshot_read: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    rd_low ##1 !sfr_rd_in ##1 (sfr_rd_in && sfr_addr_in == ADDR_COUNT_HIGH)
      |=> sfr_rdata_out == $past(count[15:8], 3))
    else $error("high byte read missed snapshot");

endmodule

/* array_counter_timebase_tb.sv */
// testbench for the array counter timebase block
// assumes the cpu model drives every input except clock and reset
`timescale 1ns/1ps
module array_counter_timebase_tb;
  import array_counter_pkg::*;
  logic       ref_clk_in;                 // system clock
  logic       rstn_in;                    // reset, active low
  logic [7:0] addr;                       // bus address
  logic       wr;                         // write strobe
  logic       rd;                         // read strobe
  logic [7:0] wdata;                      // write data
  logic [7:0] rdata;                      // read data
  logic       idle;                       // cpu idle
  logic       t0;                         // timer 0 pulse
  logic       ext;                        // count pin
  logic       osc;                        // oscillator tick
  logic       gie;                        // global enable
  logic       bie;                        // block enable
  logic       irq;                        // overflow request
  logic       wd_en;                      // watchdog enable
  logic [7:0] d;                          // read result
  int         miscompares;                // mismatches
  int         tests_run;                  // comparisons
  // timebase table, entry 0 in the low bits: mode, source, idle, ticks in 48 cycles
  localparam logic [79:0] mode_tab = {8'h08, 8'h88, 8'h0e, 8'h0c, 8'h0a,
                                      8'h08, 8'h06, 8'h04, 8'h02, 8'h00};
  localparam logic [19:0] kind_tab = {2'h0, 2'h0, 2'h0, 2'h0, 2'h3,
                                      2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
  localparam logic [9:0]  idle_tab = 10'h300;
  localparam logic [79:0] exp_tab  = {8'h30, 8'h00, 8'h00, 8'h00, 8'h04,
                                      8'h30, 8'h04, 8'h05, 8'h0c, 8'h04};
  localparam logic [39:0] cap_tab  = {ADDR_CAPTURE4_LOW, ADDR_CAPTURE3_LOW,
    ADDR_CAPTURE2_LOW, ADDR_CAPTURE1_LOW, ADDR_CAPTURE0_LOW};

  // ****************************************
  // clock, design, partner
  // ****************************************
  initial ref_clk_in = 1'b0;
  always #10 ref_clk_in = ~ref_clk_in;

  array_counter_timebase DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
    .sfr_rdata_out(rdata), .cpu_idle_in(idle), .timer0_overflow_in(t0),
    .external_count_input_in(ext), .ext_osc_div8_in(osc),
    .global_irq_enable_in(gie), .block_irq_enable_in(bie), .irq_out(irq),
    .watchdog_enable_out(wd_en));

  sfr_cpu_model cpu (.ref_clk_in(ref_clk_in), .sfr_addr_out(addr), .sfr_wr_out(wr),
    .sfr_rd_out(rd), .sfr_wdata_out(wdata), .sfr_rdata_in(rdata),
    .cpu_idle_out(idle), .timer0_out(t0), .ext_count_out(ext), .osc_div8_out(osc),
    .global_en_out(gie), .block_en_out(bie));

  // ****************************************
  // compare and verdict
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // low byte advance over 48 cycles under one mode
  task automatic measure(input int i);
    logic [7:0] a;
    logic [7:0] b;
    cpu.cpu_idle_out = idle_tab[i];
    cpu.sfr_write(ADDR_COUNTER_MODE, mode_tab[i*8 +: 8]);
    cpu.sfr_read(ADDR_COUNT_LOW, a);
    cpu.run_window(kind_tab[i*2 +: 2], 46);
    cpu.sfr_read(ADDR_COUNT_LOW, b);
    cpu.cpu_idle_out = 1'b0;
    check(8'(b - a), exp_tab[i*8 +: 8]);
  endtask

  // ****************************************
  // hang guard, far beyond the ~600 cycle run
  // ****************************************
  initial begin
    #100us;
    miscompares++;
    summarize();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    miscompares = 0;
    tests_run   = 0;
    rstn_in     = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    @(negedge ref_clk_in);
    check(wd_en, 1'b1);
    cpu.sfr_read(ADDR_COUNTER_MODE, d);
    check(d, MODE_RESET);
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h1c);
    cpu.sfr_read(ADDR_COUNTER_MODE, d);
    check(d, 8'h00);
    check(wd_en, 1'b0);
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h1c);
    cpu.sfr_read(ADDR_COUNTER_MODE, d);
    check(d, 8'h0c);
    cpu.sfr_read(8'h00, d);
    check(d, 8'h00);
    // capture low bytes, all five
    for (int i = 0; i < 5; i++) cpu.sfr_write(cap_tab[i*8 +: 8], 8'ha0 + 8'(i));
    for (int i = 0; i < 5; i++) begin
      cpu.sfr_read(cap_tab[i*8 +: 8], d);
      check(d, 8'ha0 + 8'(i));
    end
    // frozen count: snapshot beats live high byte
    cpu.sfr_write(ADDR_COUNT_LOW, 8'h34);
    cpu.sfr_write(ADDR_COUNT_HIGH, 8'h12);
    cpu.sfr_read(ADDR_COUNT_LOW, d);
    check(d, 8'h34);
    cpu.sfr_write(ADDR_COUNT_HIGH, 8'h99);
    cpu.sfr_read(ADDR_COUNT_HIGH, d);
    check(d, 8'h12);
    cpu.sfr_read(ADDR_COUNT_LOW, d);
    cpu.sfr_read(ADDR_COUNT_HIGH, d);
    check(d, 8'h99);
    for (int i = 0; i < 10; i++) measure(i);
    // wrap from the top with the interrupt enabled
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h0c);
    cpu.sfr_write(ADDR_COUNT_LOW, 8'hfe);
    cpu.sfr_write(ADDR_COUNT_HIGH, 8'hff);
    cpu.sfr_write(ADDR_COUNTER_CTRL, 8'h00);
    check(irq, 1'b0);
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h09);
    repeat (4) @(negedge ref_clk_in);
    cpu.sfr_read(ADDR_COUNTER_CTRL, d);
    check(d, 8'h80);
    check(irq, 1'b1);
    cpu.global_en_out = 1'b0;
    @(negedge ref_clk_in);
    check(irq, 1'b0);
    cpu.global_en_out = 1'b1;
    cpu.block_en_out  = 1'b0;
    @(negedge ref_clk_in);
    check(irq, 1'b0);
    cpu.block_en_out = 1'b1;
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h08);
    check(irq, 1'b0);
    cpu.sfr_read(ADDR_COUNTER_CTRL, d);
    check(d, 8'h80);
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h09);
    check(irq, 1'b1);
    cpu.sfr_write(ADDR_COUNTER_CTRL, 8'h00);
    cpu.sfr_read(ADDR_COUNTER_CTRL, d);
    check(d, 8'h00);
    check(irq, 1'b0);
    // lock holds the watchdog until reset
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h20);
    check(wd_en, 1'b1);
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h00);
    cpu.sfr_read(ADDR_COUNTER_MODE, d);
    check(d, 8'h60);
    rstn_in = 1'b0;
    @(negedge ref_clk_in);
    rstn_in = 1'b1;
    @(negedge ref_clk_in);
    cpu.sfr_write(ADDR_COUNTER_MODE, 8'h00);
    check(wd_en, 1'b0);
    summarize();
  end
endmodule

/* sfr_cpu_model.sv */
// cpu side model: register master plus the count sources it owns
// assumes every task is entered at a falling edge of ref_clk_in
`timescale 1ns/1ps
module sfr_cpu_model (
  input  wire logic       ref_clk_in,          // system clock
  output logic      [7:0] sfr_addr_out,        // register address
  output logic            sfr_wr_out,          // write strobe
  output logic            sfr_rd_out,          // read strobe
  output logic      [7:0] sfr_wdata_out,       // write data
  input  wire logic [7:0] sfr_rdata_in,        // read data
  output logic            cpu_idle_out,        // idle level
  output logic            timer0_out,          // timer 0 overflow pulse
  output logic            ext_count_out,       // external count pin
  output logic            osc_div8_out,        // divided oscillator
  output logic            global_en_out,       // global enable
  output logic            block_en_out         // block enable
);
  // ****************************************
  // idle levels at time zero
  // ****************************************
  initial begin
    sfr_addr_out  = 8'h00;
    sfr_wr_out    = 1'b0;
    sfr_rd_out    = 1'b0;
    sfr_wdata_out = 8'h00;
    cpu_idle_out  = 1'b0;
    timer0_out    = 1'b0;
    ext_count_out = 1'b1;
    osc_div8_out  = 1'b0;
    global_en_out = 1'b1;
    block_en_out  = 1'b1;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  // one-cycle write, spare cycle so strobes never merge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_out  = a;
    sfr_wdata_out = d;
    sfr_wr_out    = 1'b1;
    @(negedge ref_clk_in);
    sfr_wr_out = 1'b0;
    @(negedge ref_clk_in);
  endtask

  // one-cycle read, data taken one cycle after the strobe
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_out = a;
    sfr_rd_out   = 1'b1;
    @(negedge ref_clk_in);
    sfr_rd_out = 1'b0;
    @(negedge ref_clk_in);
    d = sfr_rdata_in;
  endtask

  // count sources for n cycles; kind 1 timer, 2 pin, 3 oscillator
  task automatic run_window(input int kind, input int n);
    for (int i = 0; i < n; i++) begin
      timer0_out    = (kind == 1) && (i % 8 == 0) && (i < 40);
      ext_count_out = !((kind == 2) && (i < 32) && ((i / 4) % 2 == 1));
      osc_div8_out  = (kind == 3) && (i < 32) && ((i / 4) % 2 == 1);
      @(negedge ref_clk_in);
    end
  endtask
endmodule
